// [hw/src_pkg.sv]
package src_pkg;
   // sequencer states
   typedef enum logic [2:0] {
      S_POR  = 3'b000,
      S_DRV  = 3'b001,
      S_HOLD = 3'b010,
      S_PIN  = 3'b011,
      S_RUN  = 3'b100,
      S_WAIT = 3'b101,
      S_STOP = 3'b110,
      S_SREC = 3'b111
   } src_state_e;

   // timing counts, in selected oscillator cycles
   localparam int          CNT_W     = 12;
   localparam logic [11:0] CNT_LONG  = 12'hFFF;  // 4096th cycle
   localparam logic [11:0] CNT_SHORT = 12'h01F;  // 32nd cycle
   localparam logic [11:0] CNT_ZERO  = 12'h000;
   localparam logic [4:0]  SEQ_LAST  = 5'h1F;    // 32 cycles per phase
   localparam logic [4:0]  SEQ_ZERO  = 5'h00;
   localparam logic [6:0]  PIN_LAST  = 7'h42;    // 67th low cycle
   localparam logic [6:0]  PIN_ZERO  = 7'h00;
   localparam logic [1:0]  DIV_LAST  = 2'h3;     // bus = osc / 4
   localparam logic [1:0]  DIV_ZERO  = 2'h0;

   // reset vectors
   localparam logic [15:0] VEC_USER  = 16'hFFFE;
   localparam logic [15:0] VEC_MON   = 16'hFEFE;

   // register byte addresses
   localparam logic [11:0] ADDR_CFG   = 12'h000;
   localparam logic [11:0] ADDR_CAUSE = 12'h004;
   localparam logic [11:0] ADDR_CNT   = 12'h008;

   // configuration fields
   localparam int         CFG_W      = 5;
   localparam int         CFG_WD_DIS = 0;  // watchdog_disable
   localparam int         CFG_SHORT  = 1;  // short_recovery_select
   localparam int         CFG_STOPEN = 2;  // stop instruction enable
   localparam int         CFG_LVI_PD = 3;  // low_voltage_power_down
   localparam int         CFG_LVI_RD = 4;  // low_voltage_reset_disable
   localparam logic [4:0] CFG_RESET  = 5'h00;

   // reset cause fields
   localparam int         CAUSE_W    = 6;
   localparam int         CA_POR     = 0;
   localparam int         CA_PIN     = 1;
   localparam int         CA_WD      = 2;
   localparam int         CA_ILLEGAL_OPCODE_FLAG    = 3;
   localparam int         CA_ILLEGAL_ADDRESS_FLAG    = 4;
   localparam int         CA_LVI     = 5;
   localparam logic [5:0] CAUSE_POR  = 6'h01;
   localparam logic [5:0] CAUSE_NONE = 6'h00;
endpackage

// [hw/src_sequencer.sv]
`timescale 1ns/10ps
module src_sequencer
   import src_pkg::*;
(
   input  wire logic        core_clk,        // selected oscillator clock
   input  wire logic        sys_rst,         // sync reset, power up
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb write
   input  wire logic [11:0] paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output logic [31:0]      prdata,          // apb read data
   output logic             pready,          // apb ready
   output logic             pslverr,         // apb error, unmapped
   input  wire logic        power_on_pulse,  // power-on detector
   input  wire logic        lvi_detect,      // supply below trip level
   input  wire logic        wdog_overflow,   // watchdog, asynchronous
   input  wire logic        illegal_opcode,  // cpu decode: bad opcode
   input  wire logic        stop_exec,       // cpu executes stop
   input  wire logic        wait_exec,       // cpu executes wait
   input  wire logic        opcode_fetch,    // cpu fetch is an opcode
   input  wire logic        addr_unmapped,   // address not mapped
   input  wire logic        wake_event,      // interrupt or break
   input  wire logic        periph_wait_run, // peripherals run in wait
   input  wire logic        monitor_mode,    // monitor mode active
   input  wire logic        rst_pin_in,      // reset pin level
   output logic             rst_pin_out,     // reset pin drive level
   output logic             rst_pin_oe,      // reset pin drive enable
   output logic             internal_reset_signal, // chip reset
   output logic [15:0]      reset_vector,    // vector fetch address
   output logic             cpu_clk_en,      // cpu bus clock pulse
   output logic             periph_clk_en,   // peripheral clock pulse
   output logic             wdog_clk_en      // watchdog prescale pulse
);
   import src_pkg::*;

   src_state_e           st_reg, st_next;
   logic [CNT_W-1:0]     cnt_reg, cnt_next;
   logic [4:0]           seq_reg;
   logic [6:0]           pin_reg;
   logic [1:0]           div_reg;
   logic [CFG_W-1:0]     cfg_reg;
   logic [CAUSE_W-1:0]   cause_reg, cause_next;
   logic                 short_reg;
   logic                 wd_meta_reg, wd_sync_reg, wd_last_reg;
   logic [31:0]          rdata_reg;
   logic [15:0]          vec_reg;
   logic                 internal_reset_signal_reg;

   // watchdog request crosses in through two flops
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wd_meta_reg <= 1'b0;
         wd_sync_reg <= 1'b0;
         wd_last_reg <= 1'b0;
      end else begin
         wd_meta_reg <= wdog_overflow;
         wd_sync_reg <= wd_meta_reg;
         wd_last_reg <= wd_sync_reg;
      end
   end

   // state decode
   wire in_run   = (st_reg == S_RUN);
   wire in_wait  = (st_reg == S_WAIT);
   wire in_stop  = (st_reg == S_STOP);
   wire in_srec  = (st_reg == S_SREC);
   wire in_por   = (st_reg == S_POR);
   wire in_drv   = (st_reg == S_DRV);
   wire in_hold  = (st_reg == S_HOLD);
   wire in_pin   = (st_reg == S_PIN);
   wire awake    = in_run | in_wait | in_stop | in_srec;

   // reset source qualification
   wire wd_edge  = wd_sync_reg & ~wd_last_reg;
   wire lvi_rst  = lvi_detect & ~cfg_reg[CFG_LVI_PD]
                 & ~cfg_reg[CFG_LVI_RD];
   wire wd_rst   = awake & wd_edge & ~cfg_reg[CFG_WD_DIS];
   wire stop_bad = stop_exec & ~cfg_reg[CFG_STOPEN];
   wire illegal_opcode_flag_rst = in_run & (illegal_opcode | stop_bad);
   wire illegal_address_flag_rst = in_run & opcode_fetch & addr_unmapped;
   wire pwr_rst  = power_on_pulse | (lvi_rst & ~in_por);
   wire int_rst  = ~pwr_rst & (wd_rst | illegal_opcode_flag_rst | illegal_address_flag_rst);
   wire pin_rst  = ~pwr_rst & ~int_rst & awake & ~rst_pin_in;
   wire stop_go  = in_run & stop_exec & cfg_reg[CFG_STOPEN];
   wire cnt_full = (cnt_reg == CNT_LONG);
   wire rec_done = short_reg ? (cnt_reg == CNT_SHORT) : cnt_full;
   wire seq_done = (seq_reg == SEQ_LAST);
   wire bus_tick = (div_reg == DIV_LAST);

   // next state; power sources win over internal, internal over pin
   always_comb begin
      st_next = st_reg;
      if (pwr_rst) begin
         st_next = S_POR;
      end else if (int_rst) begin
         st_next = S_DRV;
      end else if (pin_rst) begin
         st_next = S_PIN;
      end else begin
         unique case (st_reg)
            S_POR: begin
               if (cnt_full && !lvi_rst) begin
                  st_next = S_DRV;
               end
            end
            S_DRV: begin
               if (seq_done) begin
                  st_next = S_HOLD;
               end
            end
            S_HOLD: begin
               if (seq_done) begin
                  st_next = S_RUN;
               end
            end
            S_PIN: begin
               if (rst_pin_in) begin
                  st_next = S_HOLD;
               end
            end
            S_RUN: begin
               if (stop_go) begin
                  st_next = S_STOP;
               end else if (wait_exec) begin
                  st_next = S_WAIT;
               end
            end
            S_WAIT: begin
               if (wake_event) begin
                  st_next = S_RUN;
               end
            end
            S_STOP: begin
               if (wake_event) begin
                  st_next = S_SREC;
               end
            end
            S_SREC: begin
               if (rec_done) begin
                  st_next = S_RUN;
               end
            end
         endcase
      end
   end

   // counter: cleared by power-on, internal resets, low voltage and stop, else free
   always_comb begin
      if (pwr_rst || int_rst || stop_go || in_stop || lvi_rst) begin
         cnt_next = CNT_ZERO;
      end else begin
         cnt_next = cnt_reg + 12'h001;
      end
   end

   // cause flags: power-on clears others; set wins over a clear
   wire cause_wr = psel & penable & pwrite & (paddr == ADDR_CAUSE);
   wire [CAUSE_W-1:0] cause_clr = cause_wr ? pwdata[CAUSE_W-1:0]
                                           : CAUSE_NONE;
   wire pin_flag = in_pin & (pin_reg == PIN_LAST) & ~lvi_detect;
   wire [CAUSE_W-1:0] cause_set = {lvi_rst & ~in_por, illegal_address_flag_rst & ~pwr_rst,
                                   illegal_opcode_flag_rst & ~pwr_rst,
                                   wd_rst & ~pwr_rst, pin_flag, 1'b0};
   always_comb begin
      if (power_on_pulse) begin
         cause_next = CAUSE_POR;
      end else begin
         cause_next = (cause_reg & ~cause_clr) | cause_set;
      end
   end

   // sequencer registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_reg    <= S_POR;
         cnt_reg   <= CNT_ZERO;
         cause_reg <= CAUSE_POR;
         short_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         cause_reg <= cause_next;
         if (in_stop && wake_event) begin
            short_reg <= cfg_reg[CFG_SHORT];
         end
      end
   end

   // phase counter restarts on every state change
   always_ff @(posedge core_clk) begin
      if (sys_rst || st_next != st_reg) begin
         seq_reg <= SEQ_ZERO;
      end else if (!seq_done) begin
         seq_reg <= seq_reg + 5'h01;
      end
   end

   // low-time counter for the pin, saturating at its limit
   always_ff @(posedge core_clk) begin
      if (sys_rst || !in_pin) begin
         pin_reg <= PIN_ZERO;
      end else if (pin_reg != PIN_LAST) begin
         pin_reg <= pin_reg + 7'h01;
      end
   end

   // bus divider
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_reg <= DIV_ZERO;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // reset outputs and vector
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         internal_reset_signal_reg <= 1'b1;
         vec_reg  <= VEC_USER;
      end else begin
         internal_reset_signal_reg <= ~(st_next == S_RUN || st_next == S_WAIT
                    || st_next == S_STOP || st_next == S_SREC);
         vec_reg  <= monitor_mode ? VEC_MON : VEC_USER;
      end
   end

   // pin drive and clock enables
   assign rst_pin_out           = 1'b0;
   assign rst_pin_oe            = in_por | in_drv;
   assign internal_reset_signal = internal_reset_signal_reg;
   assign reset_vector          = vec_reg;
   assign cpu_clk_en            = in_run & bus_tick;
   assign periph_clk_en         = bus_tick
                                & (in_run | (in_wait & periph_wait_run));
   assign wdog_clk_en           = cnt_full & ~in_stop;

   // apb decode; zero wait states
   wire hit_cfg   = (paddr == ADDR_CFG);
   wire hit_cause = (paddr == ADDR_CAUSE);
   wire hit_cnt   = (paddr == ADDR_CNT);
   wire hit_any   = hit_cfg | hit_cause | hit_cnt;
   wire setup     = psel & ~penable;
   wire cfg_wr    = psel & penable & pwrite & hit_cfg;
   wire [31:0] rmux = hit_cfg   ? {27'h0, cfg_reg}   :
                      hit_cause ? {26'h0, cause_reg} :
                      hit_cnt   ? {20'h0, cnt_reg}   : 32'h0;
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = rdata_reg;

   // configuration and read data capture
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_reg   <= CFG_RESET;
         rdata_reg <= 32'h0;
      end else begin
         if (internal_reset_signal_reg) begin
            cfg_reg <= CFG_RESET;
         end else if (cfg_wr) begin
            cfg_reg <= pwdata[CFG_W-1:0];
         end
         if (setup) begin
            rdata_reg <= rmux;
         end
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   drive_len_a:
      assert property ($rose(in_hold) && $past(in_drv)
                       |-> $past(in_drv, 32))
      else $error("pin drive phase not 32 cycles");
   hold_len_a:
      assert property ($rose(in_run) && $past(in_hold)
                       |-> $past(in_hold, 32) && !internal_reset_signal
                       && $past(internal_reset_signal))
      else $error("hold phase not 32 cycles");
   por_flag_a:
      assert property (power_on_pulse |=> cause_reg == CAUSE_POR
                       && rst_pin_oe)
      else $error("power-on flags wrong");
   wdog_flag_a:
      assert property (wd_rst && !pwr_rst |=> cause_reg[CA_WD] && in_drv
                       && cnt_reg == CNT_ZERO)
      else $error("watchdog reset not taken");
   stop_illegal_opcode_flag_a:
      assert property (in_run && stop_exec && !cfg_reg[CFG_STOPEN]
                       && !pwr_rst |=> cause_reg[CA_ILLEGAL_OPCODE_FLAG] && in_drv)
      else $error("disabled stop not illegal");
   data_ok_a:
      assert property (in_run && !opcode_fetch && !illegal_opcode
                       && !stop_exec && !wait_exec && !pwr_rst && !wd_rst
                       && rst_pin_in |=> in_run)
      else $error("data access caused reset");
   wait_cpu_a:
      assert property (in_wait |-> !cpu_clk_en)
      else $error("cpu clocked in wait");
   bus_div_a:
      assert property (cpu_clk_en |=> !cpu_clk_en [*3] ##1 in_run
                       |-> cpu_clk_en)
      else $error("bus rate not quarter");
   pin_keep_a:
      assert property (pin_rst && !in_stop
                       |=> cnt_reg == $past(cnt_reg) + 12'h001)
      else $error("pin reset touched counter");
   vec_sel_a:
      assert property (internal_reset_signal && $past(monitor_mode)
                       |-> reset_vector == VEC_MON)
      else $error("wrong reset vector");

   // clock gating, flags and counter behaviour in stop, stop recovery, power-on, drive and run
   srec_gate_a:
      assert property (in_srec |-> !cpu_clk_en && !periph_clk_en)
      else $error("clocks ran during stop recovery");
   stop_gate_a:
      assert property (in_stop |-> !cpu_clk_en && !periph_clk_en
                       && !wdog_clk_en && cnt_reg == CNT_ZERO)
      else $error("stop did not hold clocks and counter");
   por_pin_a:
      assert property (in_por |-> rst_pin_oe && !rst_pin_out
                       && !cpu_clk_en && !periph_clk_en)
      else $error("power hold phase not gated");
   lvi_hold_a:
      assert property (lvi_rst |=> in_por && cnt_reg == CNT_ZERO)
      else $error("low voltage did not hold the count");
   illegal_address_flag_flag_a:
      assert property (illegal_address_flag_rst && !pwr_rst |=> cause_reg[CA_ILLEGAL_ADDRESS_FLAG] && in_drv)
      else $error("illegal address reset not taken");
   illegal_opcode_flag_flag_a:
      assert property (in_run && illegal_opcode && !pwr_rst
                       |=> cause_reg[CA_ILLEGAL_OPCODE_FLAG] && in_drv)
      else $error("illegal opcode reset not taken");
   pin_flag_a:
      assert property (pin_flag && !power_on_pulse |=> cause_reg[CA_PIN])
      else $error("pin cause flag not set");
   internal_reset_signal_level_a:
      assert property (internal_reset_signal == !awake)
      else $error("internal reset level wrong");
   cnt_free_a:
      assert property (in_run && !pwr_rst && !int_rst && !stop_go
                       |=> cnt_reg == $past(cnt_reg) + 12'h001)
      else $error("counter not free running");
   drv_pin_a:
      assert property (in_drv |-> rst_pin_oe && !rst_pin_out)
      else $error("pin not driven in drive phase");
   short_rec_a:
      assert property (in_srec && short_reg |-> cnt_reg <= CNT_SHORT)
      else $error("short recovery overran");
endmodule

// [testbench/src_pin_partner.sv]
`timescale 1ns/10ps
module src_pin_partner (
   input  wire logic       core_clk, // oscillator clock
   input  wire logic       sys_rst,  // power-up reset
   input  wire logic       pull_req, // start a low pulse
   input  wire logic [7:0] pull_len, // low pulse length
   output logic            pull_low  // pulls the shared pin low
);
   logic [7:0] left_reg;
   // counts down the cycles the other chip holds the pin low
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         left_reg <= 8'h00;
      end else if (pull_req) begin
         left_reg <= pull_len;
      end else if (left_reg != 8'h00) begin
         left_reg <= left_reg - 8'h01;
      end
   end
   // open drain: only ever pulls low, never drives high
   assign pull_low = (left_reg != 8'h00);
endmodule

// [testbench/src_sequencer_test.sv]
`timescale 1ns/10ps
module src_sequencer_test;
   import src_pkg::*;
   logic        core_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        power_on_pulse, lvi_detect, wdog_overflow, illegal_opcode;
   logic        stop_exec, wait_exec, opcode_fetch, addr_unmapped, err;
   logic        wake_event, periph_wait_run, monitor_mode, rst_pin_in;
   logic        rst_pin_out, rst_pin_oe, internal_reset_signal;
   logic        cpu_clk_en, periph_clk_en, wdog_clk_en, pull_req, pull_low;
   logic [15:0] reset_vector;
   logic [7:0]  pull_len;
   int          failures, checked, drv, hold, nc, np, nw, nr;
   int          srcbit [4] = '{CA_ILLEGAL_OPCODE_FLAG, CA_ILLEGAL_ADDRESS_FLAG, CA_WD, CA_ILLEGAL_OPCODE_FLAG};

   src_sequencer u_dut (.core_clk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on_pulse,
      .lvi_detect, .wdog_overflow, .illegal_opcode, .stop_exec,
      .wait_exec, .opcode_fetch, .addr_unmapped, .wake_event,
      .periph_wait_run, .monitor_mode, .rst_pin_in, .rst_pin_out,
      .rst_pin_oe, .internal_reset_signal, .reset_vector, .cpu_clk_en,
      .periph_clk_en, .wdog_clk_en);
   src_pin_partner u_chip (.core_clk, .sys_rst, .pull_req, .pull_len,
      .pull_low);
   // shared pin with pull-up: low when either party pulls it
   assign rst_pin_in = ~((rst_pin_oe & ~rst_pin_out) | pull_low);

   // clock generation
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   task automatic conclude();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic hang();
      failures++;
      conclude();
   endtask

   // one apb transfer, read data and error kept in rd and err
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 20) hang();
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // lengths of pin drive and of the internal reset tail after it
   task automatic measure();
      int n;
      n = 0;
      drv = 0;
      hold = 0;
      nc = 0;
      #1;
      while (rst_pin_oe !== 1'b1) begin
         @(posedge core_clk); #1;
         n++;
         if (n > 40) hang();
      end
      while (rst_pin_oe === 1'b1 && drv < 9000) begin
         @(posedge core_clk); #1;
         drv++;
         if (cpu_clk_en === 1'b1) nc++;
      end
      while (internal_reset_signal === 1'b1 && hold < 200) begin
         @(posedge core_clk); #1;
         hold++;
      end
   endtask

   // counts clock pulses and reset cycles over a span
   task automatic count_en(input int n);
      nc = 0;
      np = 0;
      nw = 0;
      nr = 0;
      repeat (n) begin
         @(posedge core_clk); #1;
         if (cpu_clk_en === 1'b1) nc++;
         if (periph_clk_en === 1'b1) np++;
         if (wdog_clk_en === 1'b1) nw++;
         if (internal_reset_signal === 1'b1) nr++;
      end
   endtask

   // enters stop, wakes, and times the first cpu clock pulse
   task automatic stop_rec(input logic [31:0] cfg);
      apb(1'b1, ADDR_CFG, cfg);
      @(posedge core_clk);
      stop_exec <= 1'b1;
      @(posedge core_clk);
      stop_exec <= 1'b0;
      count_en(50);
      chk("stop_cpu", 0, nc);
      chk("stop_wd", 0, nw);
      @(posedge core_clk);
      wake_event <= 1'b1;
      @(posedge core_clk);
      wake_event <= 1'b0;
      #1;
      nr = 0;
      while (cpu_clk_en !== 1'b1 && nr < 6000) begin
         @(posedge core_clk); #1;
         nr++;
      end
   endtask

   task automatic pin_pulse(input logic [7:0] len);
      apb(1'b1, ADDR_CAUSE, 32'h0000003F);
      @(posedge core_clk);
      pull_len <= len;
      pull_req <= 1'b1;
      @(posedge core_clk);
      pull_req <= 1'b0;
      count_en(150);
      apb(1'b0, ADDR_CAUSE, 32'h0);
   endtask

   // main sequence
   initial begin
      {psel, penable, pwrite, power_on_pulse, lvi_detect} = '0;
      {wdog_overflow, illegal_opcode, stop_exec, wait_exec} = '0;
      {opcode_fetch, addr_unmapped, wake_event, monitor_mode} = '0;
      {periph_wait_run, pull_req} = '0;
      {paddr, pwdata, pull_len} = '0;
      failures = 0;
      checked = 0;
      sys_rst = 1'b1;
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      measure();
      chk("por_hold", 32, hold);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      chk("por_cause", CAUSE_POR, rd);
      apb(1'b0, 12'h00C, 32'h0);
      chk("unmapped_err", 1, err);
      count_en(4096);
      chk("cpu_div", 1024, nc);
      chk("per_div", 1024, np);
      chk("wd_pre", 1, nw);
      for (int k = 0; k < 4; k++) begin
         @(posedge core_clk);
         monitor_mode <= k[0];
         apb(1'b1, ADDR_CAUSE, 32'h0000003F);
         apb(1'b1, ADDR_CFG, 32'h00000002);
         @(posedge core_clk);
         illegal_opcode <= (k == 0);
         opcode_fetch <= (k == 1);
         addr_unmapped <= (k == 1);
         wdog_overflow <= (k == 2);
         stop_exec <= (k == 3);
         @(posedge core_clk);
         {illegal_opcode, opcode_fetch, addr_unmapped, stop_exec} <= '0;
         measure();
         @(posedge core_clk);
         wdog_overflow <= 1'b0;
         chk("src_drv", 32, drv);
         chk("pin_out", 0, rst_pin_out);
         chk("src_hold", 32, hold);
         chk("vector", k[0] ? VEC_MON : VEC_USER, reset_vector);
         apb(1'b0, ADDR_CAUSE, 32'h0);
         chk("src_cause", 32'h1 << srcbit[k], rd);
         apb(1'b0, ADDR_CFG, 32'h0);
         chk("cfg_reset", 0, rd);
         apb(1'b0, ADDR_CNT, 32'h0);
         chk("cnt_clear", 1, rd < 32'h80);
      end
      @(posedge core_clk);
      addr_unmapped <= 1'b1;
      @(posedge core_clk);
      addr_unmapped <= 1'b0;
      count_en(20);
      chk("data_unmapped", 0, nr);
      apb(1'b1, ADDR_CFG, 32'h00000001);
      @(posedge core_clk);
      wdog_overflow <= 1'b1;
      repeat (4) @(posedge core_clk);
      wdog_overflow <= 1'b0;
      count_en(20);
      chk("wd_disabled", 0, nr);
      pin_pulse(8'd70);
      chk("pin_cause", 32'h1 << CA_PIN, rd);
      pin_pulse(8'd20);
      chk("pin_short", 0, rd);
      periph_wait_run <= 1'b1;
      @(posedge core_clk);
      wait_exec <= 1'b1;
      @(posedge core_clk);
      wait_exec <= 1'b0;
      count_en(40);
      chk("wait_cpu", 0, nc);
      chk("wait_per", 10, np);
      @(posedge core_clk);
      wake_event <= 1'b1;
      @(posedge core_clk);
      wake_event <= 1'b0;
      stop_rec(32'h00000006);
      chk("stop_short", 1, nr >= 30 && nr <= 38);
      stop_rec(32'h00000004);
      chk("stop_long", 1, nr >= 4094 && nr <= 4102);
      apb(1'b1, ADDR_CAUSE, 32'h0000003F);
      apb(1'b1, ADDR_CFG, 32'h0);
      @(posedge core_clk);
      lvi_detect <= 1'b1;
      repeat (10) @(posedge core_clk);
      lvi_detect <= 1'b0;
      measure();
      chk("lvi_drv", 1, drv >= 4128 && drv <= 4140);
      chk("lvi_hold", 32, hold);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      chk("lvi_cause", 32'h1 << CA_LVI, rd);
      @(posedge core_clk);
      power_on_pulse <= 1'b1;
      @(posedge core_clk);
      power_on_pulse <= 1'b0;
      measure();
      chk("pwr_drv", 4128, drv);
      chk("pwr_hold", 32, hold);
      chk("pwr_clk", 0, nc);
      apb(1'b0, ADDR_CAUSE, 32'h0);
      chk("pwr_cause", CAUSE_POR, rd);
      conclude();
   end
endmodule
